// ==== rtl/tgc_ctrl.sv ====
`timescale 1ns/100ps
module tgc_ctrl (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// Request side
	input  wire logic             req_valid_i,
	output logic                  req_ready_o,
	input  wire tgc_pkg::tgc_req_t req_i,
	// Answer side
	output logic                  rsp_valid_o,
	output tgc_pkg::tgc_rsp_t     rsp_o,
	// Device pins
	output tgc_pkg::tgc_pins_t    pins_o,
	input  wire logic [3:0]       dq_i,
	input  wire logic             match_i
);
	import tgc_pkg::*;

	typedef struct packed {
		tgc_state_t            state;
		tgc_op_t               op;
		logic [TGC_CNT_W-1:0]  cnt;
		logic [TGC_CNT_W-1:0]  cyc;
		tgc_pins_t             pins;
		logic                  rsp_valid;
		tgc_rsp_t              rsp;
	} tgc_ctrl_state_t;

	tgc_ctrl_state_t st_reg;
	tgc_ctrl_state_t st_next;
	logic [4:0]      sync_in;
	logic            sync_hit;
	logic [3:0]      sync_dq;

	// Match and read data come back off-chip, so synchronise them
	tgc_sync #(
		.WIDTH(5)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({match_i, dq_i}),
		.sync_o    (sync_in)
	);

	assign sync_hit = sync_in[4];
	assign sync_dq  = sync_in[3:0];

	function automatic tgc_pins_t idle_pins(input tgc_pins_t p);
		tgc_pins_t q;
		q               = p;
		q.wr_en_n       = 1'b1;
		q.rd_en_n       = 1'b1;
		q.flash_erase_n = 1'b1;
		q.dq_oe_n       = 4'hf;
		return q;
	endfunction : idle_pins

	always_comb begin
		st_next           = st_reg;
		st_next.rsp_valid = 1'b0;
		if (st_reg.cyc != TGC_CNT_RST) begin
			st_next.cyc = st_reg.cyc - 4'h1;
		end
		case (st_reg.state)
			TGC_ST_IDLE: begin
				// a new cycle waits until the minimum cycle time has elapsed
				if (req_valid_i && st_reg.cyc == TGC_CNT_RST) begin
					st_next.op             = req_i.op;
					// address set-up is zero, applied with the controls
					st_next.pins.tag_index = req_i.index;
					st_next.pins.dq_out    = req_i.data;
					st_next.state          = TGC_ST_SETUP;
					st_next.cyc            = 4'(TGC_CYC_CYCLE);
					case (req_i.op)
						TGC_OP_CLEAR: begin
							st_next.pins.flash_erase_n = 1'b0;
							st_next.pins.dq_oe_n       = 4'hf;
							st_next.cnt                = 4'(TGC_CYC_CLP);
						end
						TGC_OP_WRITE: begin
							st_next.pins.wr_en_n = 1'b0;
							st_next.pins.rd_en_n = 1'b1;
							// drive the port one cycle after write enable falls
							st_next.cnt          = 4'(TGC_CYC_WEW);
						end
						TGC_OP_READ: begin
							st_next.pins.rd_en_n = 1'b0;
							st_next.cnt          = 4'(TGC_CYC_AA);
						end
						default: begin
							// enables already high since idle; data on port
							st_next.pins.dq_oe_n = 4'h0;
							st_next.cnt          = 4'(TGC_CYC_ACA);
						end
					endcase
				end
			end
			TGC_ST_SETUP: begin
				if (st_reg.op == TGC_OP_WRITE) begin
					// data valid well before write enable rises
					st_next.pins.dq_oe_n = 4'h0;
				end
				// Two synchroniser stages add delay before sampling
				st_next.cnt   = st_reg.cnt + 4'h2;
				st_next.state = TGC_ST_STROBE;
			end
			TGC_ST_STROBE: begin
				if (st_reg.cnt != TGC_CNT_RST) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					case (st_reg.op)
						TGC_OP_COMPARE: begin
							// sampled after access time, no read/write active
							st_next.rsp.hit  = sync_hit;
							st_next.rsp.data = st_reg.pins.dq_out;
							st_next.rsp_valid = 1'b1;
						end
						TGC_OP_READ: begin
							st_next.rsp.hit   = 1'b0;
							st_next.rsp.data  = sync_dq;
							st_next.rsp_valid = 1'b1;
						end
						TGC_OP_WRITE: begin
							st_next.rsp.hit   = 1'b0;
							st_next.rsp.data  = st_reg.pins.dq_out;
							st_next.rsp_valid = 1'b1;
						end
						default: begin
							st_next.rsp.hit   = 1'b0;
							st_next.rsp.data  = 4'h0;
							st_next.rsp_valid = 1'b1;
						end
					endcase
					// enables rise only after the pulse width
					st_next.pins  = idle_pins(st_reg.pins);
					if (st_reg.op == TGC_OP_WRITE) begin
						// zero data hold, but keep driving one more cycle
						st_next.pins.dq_oe_n = 4'h0;
					end
					// Turnaround covers the slower of the two release times
					if (TGC_CYC_OEZ > TGC_CYC_WEZ) begin
						st_next.cnt = 4'(TGC_CYC_OEZ);
					end else begin
						st_next.cnt = 4'(TGC_CYC_WEZ);
					end
					st_next.state = TGC_ST_RECOVER;
				end
			end
			TGC_ST_RECOVER: begin
				// Bus turnaround so device release never overlaps our drive
				st_next.pins.dq_oe_n = 4'hf;
				if (st_reg.cnt != TGC_CNT_RST) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					st_next.state = TGC_ST_IDLE;
				end
			end
			default: begin
				st_next.state = TGC_ST_IDLE;
			end
		endcase
		// Never drive the port while the device may drive it
		if (!st_next.pins.rd_en_n || !st_next.pins.flash_erase_n) begin
			st_next.pins.dq_oe_n = 4'hf;
		end
		// Clear wins over both enables
		if (!st_next.pins.flash_erase_n) begin
			st_next.pins.wr_en_n = 1'b1;
			st_next.pins.rd_en_n = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_reg.state     <= TGC_ST_IDLE;
			st_reg.op        <= TGC_OP_COMPARE;
			st_reg.cnt       <= TGC_CNT_RST;
			st_reg.cyc       <= TGC_CNT_RST;
			st_reg.pins.tag_index     <= '0;
			st_reg.pins.wr_en_n       <= 1'b1;
			st_reg.pins.rd_en_n       <= 1'b1;
			st_reg.pins.flash_erase_n <= 1'b1;
			st_reg.pins.dq_out        <= 4'h0;
			st_reg.pins.dq_oe_n       <= 4'hf;
			st_reg.rsp_valid <= 1'b0;
			st_reg.rsp       <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready_o = (st_reg.state == TGC_ST_IDLE) && (st_reg.cyc == TGC_CNT_RST);
	assign rsp_valid_o = st_reg.rsp_valid;
	assign rsp_o       = st_reg.rsp;
	assign pins_o      = st_reg.pins;

endmodule : tgc_ctrl

// ==== rtl/tgc_pkg.sv ====
package tgc_pkg;

	localparam int TGC_ADDR_W = 12;
	localparam int TGC_DATA_W = 4;

	// Timing in ns, slowest grade by default
	localparam int TGC_CLK_NS      = 20;
	localparam int TGC_T_CYCLE_NS  = 35;
	localparam int TGC_T_CSS_NS    = 10;
	localparam int TGC_T_ACA_NS    = 35;
	localparam int TGC_T_WEW_NS    = 30;
	localparam int TGC_T_DS_NS     = 14;
	localparam int TGC_T_AA_NS     = 35;
	localparam int TGC_T_OEZ_NS    = 10;
	localparam int TGC_T_WEZ_NS    = 13;
	localparam int TGC_T_CLP_NS    = 60;

	// Least times round up
	localparam int TGC_CYC_CYCLE = (TGC_T_CYCLE_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_CSS   = (TGC_T_CSS_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_ACA   = (TGC_T_ACA_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_WEW   = (TGC_T_WEW_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_DS    = (TGC_T_DS_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_AA    = (TGC_T_AA_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_OEZ   = (TGC_T_OEZ_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_WEZ   = (TGC_T_WEZ_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;
	localparam int TGC_CYC_CLP   = (TGC_T_CLP_NS + TGC_CLK_NS - 1) / TGC_CLK_NS;

	localparam int TGC_CNT_W = 4;
	localparam logic [TGC_CNT_W-1:0] TGC_CNT_RST = 4'h0;

	typedef enum logic [1:0] {
		TGC_OP_COMPARE = 2'h0,
		TGC_OP_READ    = 2'h1,
		TGC_OP_WRITE   = 2'h2,
		TGC_OP_CLEAR   = 2'h3
	} tgc_op_t;

	typedef struct packed {
		tgc_op_t                 op;
		logic [TGC_ADDR_W-1:0]   index;
		logic [TGC_DATA_W-1:0]   data;
	} tgc_req_t;

	typedef struct packed {
		logic                    hit;
		logic [TGC_DATA_W-1:0]   data;
	} tgc_rsp_t;

	// Pins toward the tag memory, enables active low
	typedef struct packed {
		logic [TGC_ADDR_W-1:0]   tag_index;
		logic                    wr_en_n;
		logic                    rd_en_n;
		logic                    flash_erase_n;
		logic [TGC_DATA_W-1:0]   dq_out;
		logic [TGC_DATA_W-1:0]   dq_oe_n;
	} tgc_pins_t;

	// Gray sequence along idle -> setup -> strobe -> recover
	typedef enum logic [1:0] {
		TGC_ST_IDLE    = 2'b00,
		TGC_ST_SETUP   = 2'b01,
		TGC_ST_STROBE  = 2'b11,
		TGC_ST_RECOVER = 2'b10
	} tgc_state_t;

endpackage : tgc_pkg

// ==== rtl/tgc_sync.sv ====
`timescale 1ns/100ps
module tgc_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// Async in, synced out
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	import tgc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} tgc_sync_state_t;

	tgc_sync_state_t st_reg;
	tgc_sync_state_t st_next;

	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = async_i;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_o = st_reg.stage2;

endmodule : tgc_sync

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	import tgc_pkg::*;
	logic       core_clk_i  = 1'b0;
	logic       rst_n_i     = 1'b0;
	logic       req_valid_i = 1'b0;
	tgc_req_t   req_i       = '0;
	logic       req_ready_o;
	logic       rsp_valid_o;
	tgc_rsp_t   rsp_o;
	tgc_pins_t  pins_o;
	logic [3:0] dq_i;
	logic       match_i;
	int         errors = 0;
	int         checks = 0;
	always #10 core_clk_i = ~core_clk_i;
	tgc_ctrl u_dut (.core_clk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_i, .rsp_valid_o,
		.rsp_o, .pins_o, .dq_i, .match_i);
	tgc_tag_model u_tag (.pins_i(pins_o), .dq_o(dq_i), .match_o(match_i));
	task automatic chk(string name, logic [3:0] seen, logic [3:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	// Request held until a take edge; answer pulse seen at a falling edge
	task automatic run_op(tgc_op_t op, logic [11:0] idx, logic [3:0] d);
		int n;
		@(negedge core_clk_i);
		req_valid_i = 1'b1;
		req_i = '{op: op, index: idx, data: d};
		n = 0;
		while (req_ready_o !== 1'b1 && n < 50) begin
			@(negedge core_clk_i);
			n++;
		end
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 50) begin
			@(negedge core_clk_i);
			n++;
		end
		chk("answer", {3'h0, rsp_valid_o}, 4'h1);
	endtask : run_op
	task automatic t_write_compare;
		run_op(TGC_OP_WRITE, 12'hfff, 4'ha);
		run_op(TGC_OP_COMPARE, 12'hfff, 4'ha);
		chk("hit", {3'h0, rsp_o.hit}, 4'h1);
		run_op(TGC_OP_COMPARE, 12'hfff, 4'hb);
		chk("miss", {3'h0, rsp_o.hit}, 4'h0);
		$display("test write_compare done");
	endtask : t_write_compare
	task automatic t_read;
		run_op(TGC_OP_WRITE, 12'h000, 4'h3);
		run_op(TGC_OP_READ, 12'h000, 4'h0);
		chk("read low", rsp_o.data, 4'h3);
		run_op(TGC_OP_READ, 12'hfff, 4'h0);
		chk("read high", rsp_o.data, 4'ha);
		run_op(TGC_OP_READ, 12'h001, 4'h0);
		chk("read untouched", rsp_o.data, 4'h5);
		$display("test read done");
	endtask : t_read
	task automatic t_clear;
		run_op(TGC_OP_CLEAR, 12'h000, 4'h0);
		run_op(TGC_OP_READ, 12'hfff, 4'h0);
		chk("cleared", rsp_o.data, 4'h0);
		run_op(TGC_OP_COMPARE, 12'h000, 4'h0);
		chk("zero hit", {3'h0, rsp_o.hit}, 4'h1);
		$display("test clear done");
	endtask : t_clear
	initial begin
		repeat (5) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_write_compare();
		t_read();
		t_clear();
		report_and_stop();
	end
	// About 10 operations of some 10 cycles; far above that is a hang
	initial begin
		#20000;
		errors++;
		report_and_stop();
	end
endmodule : tb_top

// ==== testbench/tgc_ctrl_assertions.sv ====
`timescale 1ns/100ps
module tgc_ctrl_assertions (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	// Ports watched
	input  wire logic              req_valid_i,
	input  wire logic              req_ready_o,
	input  wire tgc_pkg::tgc_req_t req_i,
	input  wire logic              rsp_valid_o,
	input  wire tgc_pkg::tgc_rsp_t rsp_o,
	input  wire tgc_pkg::tgc_pins_t pins_o,
	input  wire logic [3:0]        dq_i,
	input  wire logic              match_i
);
	import tgc_pkg::*;
	logic take;
	assign take = req_valid_i && req_ready_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	cmp_lat_a: assert property (take && req_i.op == TGC_OP_COMPARE |-> ##7 rsp_valid_o)
		else $error("compare answer late");
	wr_lat_a: assert property (take && req_i.op == TGC_OP_WRITE |-> ##7 rsp_valid_o)
		else $error("write answer late");
	rd_lat_a: assert property (take && req_i.op == TGC_OP_READ |-> ##7 rsp_valid_o)
		else $error("read answer late");
	erase_lat_a: assert property (take && req_i.op == TGC_OP_CLEAR |-> ##8 rsp_valid_o)
		else $error("clear answer late");
	take_stall_a: assert property (take |=> !req_ready_o)
		else $error("back to back take");
	wr_width_a: assert property ($fell(pins_o.wr_en_n) |-> (!pins_o.wr_en_n)[*2])
		else $error("write strobe short");
	erase_width_a: assert property ($fell(pins_o.flash_erase_n) |-> (!pins_o.flash_erase_n)[*3])
		else $error("clear pulse short");
	wr_index_a: assert property ($past(!pins_o.wr_en_n) |-> $stable(pins_o.tag_index))
		else $error("index moved in write");
	wr_data_a: assert property ($rose(pins_o.wr_en_n) |-> $past(pins_o.dq_oe_n) == 4'h0)
		else $error("write data not set up");
	rd_nodrive_a: assert property (!pins_o.rd_en_n |-> pins_o.dq_oe_n == 4'hf)
		else $error("bus contention on read");
	erase_quiet_a: assert property (!pins_o.flash_erase_n |-> pins_o.wr_en_n && pins_o.rd_en_n)
		else $error("enables active in clear");
	cover property (take && req_i.op == TGC_OP_COMPARE);
	cover property (take && req_i.op == TGC_OP_READ);
	cover property (take && req_i.op == TGC_OP_CLEAR);
	cover property (take && req_i.op == TGC_OP_WRITE);
endmodule : tgc_ctrl_assertions

bind tgc_ctrl tgc_ctrl_assertions u_chk (.core_clk_i, .rst_n_i, .req_valid_i, .req_ready_o,
	.req_i, .rsp_valid_o, .rsp_o, .pins_o, .dq_i, .match_i);

// ==== testbench/tgc_tag_model.sv ====
`timescale 1ns/100ps
module tgc_tag_model (
	// Pins from controller
	input  wire tgc_pkg::tgc_pins_t pins_i,
	// Levels seen by controller
	output logic [3:0]              dq_o,
	output logic                    match_o
);
	import tgc_pkg::*;
	logic [3:0] mem [4096];
	logic [3:0] bus;
	logic       rd;
	logic       cmp;
	assign rd = !pins_i.rd_en_n && pins_i.wr_en_n && pins_i.flash_erase_n;
	assign cmp = pins_i.rd_en_n && pins_i.wr_en_n && pins_i.flash_erase_n;
	// Released lines sit at the pull-up level
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bus[i] = !pins_i.dq_oe_n[i] ? pins_i.dq_out[i] :
				(rd ? mem[pins_i.tag_index][i] : 1'b1);
		end
	end
	assign #12 dq_o = bus;
	// Invalid match shows the wrong answer, never a kind one
	assign #20 match_o = cmp ? (mem[pins_i.tag_index] == bus) :
		(mem[pins_i.tag_index] != bus);
	initial begin
		foreach (mem[i]) mem[i] = 4'h5;
	end
	always @(posedge pins_i.wr_en_n) begin
		if (pins_i.flash_erase_n) mem[pins_i.tag_index] = bus;
	end
	always @(negedge pins_i.flash_erase_n) begin
		foreach (mem[i]) mem[i] = 4'h0;
	end
endmodule : tgc_tag_model
